// ==== rtl/amu_top.sv ====
// Purpose: Address pointer update arithmetic with per-pointer modifiers
// Assumes: Decode stage drives one request per cycle, no back-pressure
// Notes:   Result two cycles after request; modifiers over APB
`timescale 1ns/10ps
`include "amu_defs.svh"

// Contract
// - Each pointer owns a modifier word; only its contents pick the arithmetic.
// - All four arithmetic types work with every register-indirect update mode.
// - Upper eight modifier bits are ignored; unlisted encodings are reserved.
// - Low sixteen bits all ones gives plain 24-bit wrapping addition.
// - Linear offset behaves the same read as signed or unsigned.
// - Modifier zero adds with carry running from MSB toward LSB.
// - Modulus equals modifier plus one, from 2 up to 32768.
// - Modulo base clears the k low pointer bits, 2^k the least cover of M.
// - Modulo pointer may start anywhere inside its buffer.
// - Modulo step past top wraps to base; below base wraps to top.
// - Modulo offset of P times 2^k moves the pointer P whole blocks.
// - Bit 15 set, bit 14 clear selects multiple wrap; low 14 bits hold M-1.
// - Multiple wrap base has k zero low bits; wraps like modulo at both ends.
// - Multiple wrap handles offsets of any size, wrapping as often as needed.
// - Unit steps in multiple wrap wrap at most once per update.
// - Post modes address with the old pointer then write the update back.
// - Indexed mode addresses pointer plus offset, leaving the pointer unchanged.
module amu_top
  import amu_pkg::*;
#(
  parameter int NUM_PTR = `AMU_NUM_PTR
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_b,
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [`AMU_PADDR_W-1:0] i_paddr,
  input  wire logic [31:0]             i_pwdata,
  output logic                         o_pready,
  output logic      [31:0]             o_prdata,
  output logic                         o_pslverr,
  input  wire amu_req_t                i_req,
  output amu_res_t                     o_res
);

  localparam int AW = `AMU_AW;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Mirror the bit order of an address word
  function automatic logic [AW-1:0] bit_rev(input logic [AW-1:0] v);
    logic [AW-1:0] r;
    r = '0;
    for (int i = 0; i < AW; i++)
      r[i] = v[AW-1-i];
    return r;
  endfunction

  // Ones in every position up to the top set bit of v
  function automatic logic [15:0] fill_mask(input logic [15:0] v);
    logic [15:0] f;
    f = v;
    f = f | (f >> 1);
    f = f | (f >> 2);
    f = f | (f >> 4);
    f = f | (f >> 8);
    return f;
  endfunction

  // Arithmetic type from the low sixteen modifier bits
  function automatic amu_arith_t arith_of(input logic [15:0] m);
    amu_arith_t a;
    if (m == `AMU_M_LINEAR)
      a = AMU_AR_LINEAR;
    else if (m == `AMU_M_REVERSE)
      a = AMU_AR_REVERSE;
    else if (!m[`AMU_MW_BIT_HI])
      a = AMU_AR_MODULO;
    else if (m[`AMU_MW_BIT_HI:`AMU_MW_BIT_LO] == `AMU_MW_TAG)
      a = AMU_AR_MULTI;
    else
      a = AMU_AR_RESERVED;
    return a;
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [AW-1:0] apb_mod_rd;
  logic [AW-1:0] mod_q;
  logic [15:0]   upd_count;
  amu_arith_t    last_arith;

  wire       aligned    = (i_paddr[1:0] == 2'h0);
  wire       hit_mod    = aligned && (i_paddr >= `AMU_OFF_MOD0)
                          && (i_paddr < `AMU_OFF_MOD0 + 8'(4 * NUM_PTR));
  wire       hit_status = (i_paddr == `AMU_OFF_STATUS);
  wire [`AMU_IDX_W-1:0] apb_idx = `AMU_IDX_W'((i_paddr - `AMU_OFF_MOD0) >> 2);
  wire       access     = i_psel && i_penable;
  wire       apb_we     = access && o_pready && i_pwrite && hit_mod;
  wire [31:0] status_word = {13'h0000, last_arith, upd_count};
  wire [31:0] read_word  = hit_mod    ? {8'h00, apb_mod_rd} :
                           hit_status ? status_word : 32'h0000_0000;

  // One wait state: answer in the second access cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (access && !o_pready) begin
      o_pready  <= 1'b1;
      o_prdata  <= i_pwrite ? 32'h0000_0000 : read_word;
      o_pslverr <= !(hit_mod || hit_status);
    end else begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Modifier storage, one word per pointer
  // ----------------------------------------------------------------
  amu_mod_mem #(
    .NUM (NUM_PTR),
    .W   (AW),
    .RST (`AMU_MOD_RESET)
  ) u_mod_mem (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_we      (apb_we),
    .i_waddr   (apb_idx),
    .i_wdata   (i_pwdata[AW-1:0]),
    .i_raddr_a (apb_idx),
    .o_rdata_a (apb_mod_rd),
    .i_raddr_b (i_req.idx),
    .o_rdata_b (mod_q)
  );

  // ----------------------------------------------------------------
  // Stage one: request held beside its modifier
  // ----------------------------------------------------------------
  amu_req_t req_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b)
      req_q <= '0;
    else
      req_q <= i_req;
  end

  // ----------------------------------------------------------------
  // Step selection per update mode
  // ----------------------------------------------------------------
  wire        use_off  = (req_q.op == AMU_OP_POST_ADD) || (req_q.op == AMU_OP_POST_SUB)
                         || (req_q.op == AMU_OP_INDEXED);
  wire        sub      = (req_q.op == AMU_OP_POST_DEC) || (req_q.op == AMU_OP_POST_SUB)
                         || (req_q.op == AMU_OP_PRE_DEC);
  wire [AW-1:0] step   = use_off ? req_q.off : 24'h000001;
  wire [AW-1:0] eff    = sub ? AW'(~step + 24'h000001) : step;
  wire [15:0]   m      = mod_q[15:0];
  amu_arith_t   arith;
  assign arith = arith_of(m);

  // ----------------------------------------------------------------
  // Linear and reverse-carry sums
  // ----------------------------------------------------------------
  wire [AW-1:0] lin_sum = AW'(req_q.ptr + eff);
  wire [AW-1:0] rev_a   = bit_rev(req_q.ptr);
  wire [AW-1:0] rev_b   = bit_rev(step);
  wire [AW-1:0] rev_s   = sub ? AW'(rev_a - rev_b) : AW'(rev_a + rev_b);
  wire [AW-1:0] rev_sum = bit_rev(rev_s);

  // ----------------------------------------------------------------
  // Modulo sum inside a block of 2^k words
  // ----------------------------------------------------------------
  wire [15:0]   mod_mask16 = fill_mask(m);
  wire [AW-1:0] mod_mask   = {8'h00, mod_mask16};
  wire [AW-1:0] mod_base   = req_q.ptr & ~mod_mask;
  wire [AW-1:0] mod_rel    = req_q.ptr & mod_mask;
  wire signed [25:0] m_s   = $signed({10'h000, m});
  wire signed [25:0] msize = m_s + 26'sh0000001;
  wire signed [25:0] rel_s = $signed({2'h0, mod_rel}) + $signed({{2{eff[AW-1]}}, eff});
  wire signed [25:0] wrap_s = (rel_s > m_s)      ? rel_s - msize :
                              (rel_s < 26'sh0)   ? rel_s + msize : rel_s;
  wire          blk_mult   = (step != 24'h000000) && ((step & mod_mask) == 24'h000000);
  wire [AW-1:0] mod_sum    = blk_mult ? lin_sum
                                      : (mod_base | AW'(wrap_s));

  // ----------------------------------------------------------------
  // Multiple wrap-around sum, mask is M-1 directly
  // ----------------------------------------------------------------
  wire [AW-1:0] mw_mask = {10'h000, m[13:0]};
  wire [AW-1:0] mw_sum  = (req_q.ptr & ~mw_mask) | (lin_sum & mw_mask);

  // ----------------------------------------------------------------
  // Arithmetic selection
  // ----------------------------------------------------------------
  logic [AW-1:0] next_sum;

  always_comb begin
    case (arith)
      AMU_AR_LINEAR:  next_sum = lin_sum;
      AMU_AR_REVERSE: next_sum = rev_sum;
      AMU_AR_MODULO:  next_sum = mod_sum;
      AMU_AR_MULTI:   next_sum = mw_sum;
      default:        next_sum = lin_sum;
    endcase
  end

  // ----------------------------------------------------------------
  // Operand address and write-back per mode
  // ----------------------------------------------------------------
  amu_res_t next_res;

  always_comb begin
    next_res       = '0;
    next_res.valid = req_q.valid;
    next_res.idx   = req_q.idx;
    case (req_q.op)
      AMU_OP_NONE: begin
        next_res.addr    = req_q.ptr;
        next_res.new_ptr = req_q.ptr;
        next_res.wr_ptr  = 1'b0;
      end
      AMU_OP_INDEXED: begin
        next_res.addr    = next_sum;
        next_res.new_ptr = req_q.ptr;
        next_res.wr_ptr  = 1'b0;
      end
      AMU_OP_PRE_DEC: begin
        next_res.addr    = next_sum;
        next_res.new_ptr = next_sum;
        next_res.wr_ptr  = req_q.valid;
      end
      AMU_OP_POST_INC, AMU_OP_POST_DEC, AMU_OP_POST_ADD, AMU_OP_POST_SUB: begin
        next_res.addr    = req_q.ptr;
        next_res.new_ptr = next_sum;
        next_res.wr_ptr  = req_q.valid;
      end
      default: begin
        next_res.addr    = req_q.ptr;
        next_res.new_ptr = req_q.ptr;
        next_res.wr_ptr  = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Stage two: registered result and status
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b)
      o_res <= '0;
    else
      o_res <= next_res;
  end

  // Last arithmetic type used and count of valid requests, any mode
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      last_arith <= AMU_AR_LINEAR;
      upd_count  <= 16'h0000;
    end else if (req_q.valid) begin
      last_arith <= arith;
      upd_count  <= 16'(upd_count + 16'h0001);
    end
  end

endmodule

// ==== rtl/amu_defs.svh ====
// Purpose: Constants of the address modifier arithmetic unit
// Assumes: APB data 32 bits, one aligned word per register
// Notes:   Definitions only
`ifndef AMU_DEFS_SVH
`define AMU_DEFS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define AMU_AW          24
`define AMU_NUM_PTR     8
`define AMU_IDX_W       3
`define AMU_PADDR_W     8

// ----------------------------------------------------------------
// Register map, byte addresses
// ----------------------------------------------------------------
`define AMU_OFF_MOD0    8'h00
`define AMU_OFF_STATUS  8'h20
`define AMU_MOD_RESET   24'hFFFFFF

// ----------------------------------------------------------------
// Modifier encodings, low 16 bits
// ----------------------------------------------------------------
`define AMU_M_LINEAR    16'hFFFF
`define AMU_M_REVERSE   16'h0000
`define AMU_MW_TAG      2'h2
`define AMU_MW_BIT_HI   15
`define AMU_MW_BIT_LO   14

`endif

// ==== rtl/amu_pkg.sv ====
// Purpose: Types of the address modifier arithmetic unit
// Assumes: amu_defs.svh holds all numbers
// Notes:   Request and result travel as packed structs
`include "amu_defs.svh"

package amu_pkg;

  // Register-indirect update modes
  typedef enum logic [2:0] {
    AMU_OP_NONE, AMU_OP_POST_INC, AMU_OP_POST_DEC, AMU_OP_POST_ADD,
    AMU_OP_POST_SUB, AMU_OP_INDEXED, AMU_OP_PRE_DEC
  } amu_op_t;

  // Arithmetic types selected by the modifier
  typedef enum logic [2:0] {
    AMU_AR_LINEAR, AMU_AR_REVERSE, AMU_AR_MODULO, AMU_AR_MULTI, AMU_AR_RESERVED
  } amu_arith_t;

  typedef struct packed {
    logic                  valid;
    logic [`AMU_IDX_W-1:0] idx;
    amu_op_t               op;
    logic [`AMU_AW-1:0]    ptr;
    logic [`AMU_AW-1:0]    off;
  } amu_req_t;

  typedef struct packed {
    logic                  valid;
    logic [`AMU_IDX_W-1:0] idx;
    logic [`AMU_AW-1:0]    addr;
    logic [`AMU_AW-1:0]    new_ptr;
    logic                  wr_ptr;
  } amu_res_t;

endpackage

// ==== rtl/amu_mod_mem.sv ====
// Purpose: Modifier register storage, one word per address pointer
// Assumes: One write port, two read ports with registered data
// Notes:   Read data appear one cycle after the address
`timescale 1ns/10ps

module amu_mod_mem #(
  parameter int          NUM = 8,
  parameter int          W   = 24,
  parameter logic [W-1:0] RST = '1
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_b,
  input  wire logic                   i_we,
  input  wire logic [$clog2(NUM)-1:0] i_waddr,
  input  wire logic [W-1:0]           i_wdata,
  input  wire logic [$clog2(NUM)-1:0] i_raddr_a,
  output logic      [W-1:0]           o_rdata_a,
  input  wire logic [$clog2(NUM)-1:0] i_raddr_b,
  output logic      [W-1:0]           o_rdata_b
);

  localparam int IW = $clog2(NUM);

  logic [W-1:0] mem [NUM];

  // ----------------------------------------------------------------
  // Storage words, reset to linear arithmetic
  // ----------------------------------------------------------------
  generate
    for (genvar g = 0; g < NUM; g++) begin : g_word
      always_ff @(posedge i_clk) begin
        if (!i_rst_b)
          mem[g] <= RST;
        else if (i_we && i_waddr == IW'(g))
          mem[g] <= i_wdata;
      end
    end
  endgenerate

  // Registered read ports
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rdata_a <= '0;
      o_rdata_b <= '0;
    end else begin
      o_rdata_a <= mem[i_raddr_a];
      o_rdata_b <= mem[i_raddr_b];
    end
  end

endmodule

// ==== bench/amu_checker_assertions.sv ====
// Purpose: Port checker of the address modifier unit
// Assumes: One clock, synchronous active-low reset
// Notes:   Shadows modifier writes to check update arithmetic
`timescale 1ns/10ps
`include "amu_defs.svh"

module amu_checker
  import amu_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  input wire amu_req_t    i_req,
  input wire amu_res_t    o_res
);
  // ----
  // Modifier shadow
  // ----
  logic [23:0] mods [`AMU_NUM_PTR];
  logic [23:0] m_q1;
  logic [23:0] m_q2;
  wire         mod_hit = i_psel && i_penable && o_pready && i_paddr < `AMU_OFF_STATUS && i_paddr[1:0] == 2'h0;
  wire  [23:0] wrap    = {10'h0, m_q2[13:0]};

  // Write lands where pready is sampled
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      mods <= '{default: `AMU_MOD_RESET};
    end else if (mod_hit && i_pwrite) begin
      mods[i_paddr[4:2]] <= i_pwdata[23:0];
    end
  end

  // Modifier seen at the request edge, aligned with the result
  always_ff @(posedge i_clk) begin
    m_q1 <= mods[i_req.idx];
    m_q2 <= m_q1;
  end

  // ----
  // Properties
  // ----
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_res_latency: assert property (i_req.valid |-> ##2 o_res.valid)
    else $error("result not two cycles after request");
  a_res_origin: assert property (o_res.valid |-> $past(i_req.valid, 2) && o_res.idx == $past(i_req.idx, 2))
    else $error("result without matching request");
  a_post_addr: assert property (o_res.valid && $past(i_req.op, 2) inside {AMU_OP_POST_INC, AMU_OP_POST_DEC,
    AMU_OP_POST_ADD, AMU_OP_POST_SUB} |-> o_res.wr_ptr && o_res.addr == $past(i_req.ptr, 2))
    else $error("post mode address or write back wrong");
  a_index_keep: assert property (o_res.valid && $past(i_req.op, 2) == AMU_OP_INDEXED |-> !o_res.wr_ptr)
    else $error("indexed mode wrote the pointer");
  a_linear_inc: assert property (o_res.valid && m_q2[15:0] == 16'hFFFF && $past(i_req.op, 2) == AMU_OP_POST_INC
    |-> o_res.new_ptr == $past(i_req.ptr, 2) + 24'h1)
    else $error("linear increment wrong");
  a_multi_dec: assert property (o_res.valid && m_q2[15:14] == 2'h2 && $past(i_req.op, 2) == AMU_OP_POST_DEC
    |-> o_res.new_ptr == (($past(i_req.ptr, 2) & ~wrap) | (($past(i_req.ptr, 2) - 24'h1) & wrap)))
    else $error("multiple wrap decrement wrong");
  a_apb_wait: assert property (i_psel && !i_penable |=> !o_pready ##1 o_pready)
    else $error("register access wait wrong");
  a_mod_read: assert property (mod_hit && !i_pwrite |-> o_prdata == {8'h0, mods[i_paddr[4:2]]} && !o_pslverr)
    else $error("modifier read back wrong");

  c_modulo: cover property (o_res.valid && !m_q2[15] && m_q2[15:0] != 16'h0);
  c_multi:  cover property (o_res.valid && m_q2[15:14] == 2'h2);
  c_error:  cover property (o_pready && o_pslverr);
  c_reverse: cover property (o_res.valid && m_q2[15:0] == 16'h0000);
endmodule

bind amu_top amu_checker u_amu_checker (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .i_req(i_req), .o_res(o_res));

// ==== bench/amu_dec_model.sv ====
// Purpose: Decode stage model holding the address pointers
// Assumes: Bench loads pointers before issuing requests
// Notes:   Idle request pointer and offset toggle so stale values cannot pass
`timescale 1ns/10ps
`include "amu_defs.svh"

module amu_dec_model
  import amu_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_go,
  input  wire logic                  i_ld,
  input  wire logic [`AMU_IDX_W-1:0] i_idx,
  input  wire amu_op_t               i_op,
  input  wire logic [`AMU_AW-1:0]    i_ptr,
  input  wire logic [`AMU_AW-1:0]    i_off,
  input  wire amu_res_t              i_res,
  output amu_req_t                   o_req
);
  logic [`AMU_AW-1:0] ptrs [`AMU_NUM_PTR];

  // One request per go, pointer from the local file
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_req <= '0;
    end else begin
      o_req.valid <= i_go;
      o_req.idx   <= i_idx;
      o_req.op    <= i_op;
      o_req.ptr   <= i_go ? ptrs[i_idx] : ~o_req.ptr;
      o_req.off   <= i_go ? i_off : ~o_req.off;
    end
  end

  // Pointer loads and write back of updates
  always_ff @(posedge i_clk) begin
    if (i_ld) begin
      ptrs[i_idx] <= i_ptr;
    end
    if (i_res.valid && i_res.wr_ptr) begin
      ptrs[i_res.idx] <= i_res.new_ptr;
    end
  end
endmodule

// ==== bench/tb.sv ====
// Purpose: Self-checking bench of the address modifier unit
// Assumes: Decode model issues requests, APB master sets modifiers
// Notes:   Reference arithmetic in integers, results in a queue
`timescale 1ns/10ps
`include "amu_defs.svh"

module tb
  import amu_pkg::*;
;
  // ----
  // Signals
  // ----
  localparam logic [15:0] MTAB [8] = '{16'hFFFF, 16'h0000, 16'h0001, 16'h0004,
                                       16'h7FFF, 16'h8001, 16'h8007, 16'hBFFF};
  logic        i_clk;
  logic        i_rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  amu_req_t    req;
  amu_res_t    res;
  logic        go;
  logic        ld;
  logic [2:0]  idx;
  amu_op_t     op;
  logic [23:0] ptr;
  logic [23:0] off;
  int          miscompares;
  int          n_tests;
  int          cyc;
  integer      seed;
  logic [23:0] mm [8];
  logic [23:0] pm [8];
  logic [51:0] expq [$];

  always #2.5 i_clk = ~i_clk;

  amu_top u_amu_top (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_req(req), .o_res(res));
  amu_dec_model u_amu_dec_model (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_go(go), .i_ld(ld), .i_idx(idx),
    .i_op(op), .i_ptr(ptr), .i_off(off), .i_res(res), .o_req(req));

  // ----
  // Reference and tasks
  // ----
  // Returns write flag, operand address and new pointer
  function automatic logic [48:0] expect_upd(input logic [23:0] m, input amu_op_t o,
                                             input logic [23:0] p, input logic [23:0] n);
    logic [23:0] t;
    logic [23:0] q;
    logic [23:0] b;
    logic        dn;
    int          s;
    int          sz;
    int          k;
    t = (o inside {AMU_OP_POST_ADD, AMU_OP_POST_SUB, AMU_OP_INDEXED}) ? n : {23'h0, o != AMU_OP_NONE};
    dn = o inside {AMU_OP_POST_DEC, AMU_OP_POST_SUB, AMU_OP_PRE_DEC};
    s = $signed(t);
    s = dn ? -s : s;
    sz = int'(m[14:0]) + 1;
    k = $clog2(sz);
    b = p >> k << k;
    if (m[15:0] == 16'h0000) begin
      q = {<<{p}};
      t = {<<{t}};
      q = dn ? q - t : q + t;
      q = {<<{q}};
    end else if (!m[15] && s % (1 << k) != 0) begin
      s = int'(p - b) + s;
      s = s >= sz ? s - sz : (s < 0 ? s + sz : s);
      q = b + 24'(s);
    end else if (m[15:14] == 2'h2) begin
      q = (p & ~{10'h0, m[13:0]}) | (24'(p + s) & {10'h0, m[13:0]});
    end else begin
      q = 24'(p + s);
    end
    expect_upd = {dn || (o inside {AMU_OP_POST_INC, AMU_OP_POST_ADD}),
                  (o inside {AMU_OP_INDEXED, AMU_OP_PRE_DEC}) ? q : p, q};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1) @(posedge i_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk_apb(input logic [31:0] q, input logic e, input logic [32:0] x);
    n_tests++;
    if ({e, q} !== x) begin
      miscompares++;
      $display("Error %0t: register access got %h expected %h", $time, {e, q}, x);
    end
  endtask

  task automatic chk_res(input amu_res_t g, input logic [51:0] x);
    n_tests++;
    if (g.idx !== x[51:49] || g.wr_ptr !== x[48] || g.addr !== x[47:24] || (x[48] && g.new_ptr !== x[23:0])) begin
      miscompares++;
      $display("Error %0t: update result %h expected %h", $time, g, x);
    end
  endtask

  task automatic conclude;
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----
  // Stimulus and checking
  // ----
  initial begin
    logic [31:0] q;
    logic        e;
    logic [48:0] x;
    logic [23:0] nv;
    amu_op_t     o;
    int          j;
    int          sz;
    int          k;
    int          rnd;
    logic [2:0]  ar;
    seed = 32'h5F0F;
    i_clk = 1'b0;
    i_rst_b = 1'b0;
    {psel, penable, pwrite, go, ld, paddr, pwdata, idx, ptr, off} = '0;
    op = AMU_OP_NONE;
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    apb(1'b1, 8'h01, 32'h0, q, e);
    chk_apb(q, e, 33'h1_0000_0000);
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk_apb(q, e, 33'h0_00FF_FFFF);
    apb(1'b0, 8'h24, 32'h0, q, e);
    chk_apb(q, e, 33'h1_0000_0000);
    for (int b = 0; b < 8; b++) begin
      for (int i = 0; i < 8; i++) begin
        mm[i] = {8'($random(seed)), MTAB[(b + i) % 8]};
        apb(1'b1, 8'(i * 4), {8'($random(seed)), mm[i]}, q, e);
        apb(1'b0, 8'(i * 4), 32'h0, q, e);
        chk_apb(q, e, {9'h0, mm[i]});
        sz = int'(mm[i][14:0]) + 1;
        k = $clog2(sz);
        pm[i] = 24'($random(seed));
        if (!mm[i][15] && mm[i][15:0] != 16'h0) pm[i] = (pm[i] >> k << k) + 24'({$random(seed)} % sz);
        @(posedge i_clk);
        ld <= 1'b1;
        idx <= 3'(i);
        ptr <= pm[i];
      end
      for (int r = 0; r < 48; r++) begin
        j = r % 8;
        rnd = $random(seed);
        o = amu_op_t'({$random(seed)} % 7);
        sz = int'(mm[j][14:0]) + 1;
        k = $clog2(sz);
        nv = 24'(rnd);
        if (!mm[j][15] && mm[j][15:0] != 16'h0) begin
          nv = rnd[2:0] == 3'h0 ? 24'((rnd[4:3] + 1) << k) : 24'({$random(seed)} % (2 * sz + 1) - sz);
        end
        x = expect_upd(mm[j], o, pm[j], nv);
        expq.push_back({3'(j), x});
        if (x[48]) pm[j] = x[23:0];
        @(posedge i_clk);
        ld <= 1'b0;
        go <= 1'b1;
        idx <= 3'(j);
        op <= o;
        off <= nv;
      end
      @(posedge i_clk);
      go <= 1'b0;
      repeat (6) @(posedge i_clk);
      // Status: ignored write, then request count and last arithmetic type
      ar = mm[7][15:0] == 16'hFFFF ? 3'h0 : (mm[7][15:0] == 16'h0000 ? 3'h1 : (mm[7][15] ? 3'h3 : 3'h2));
      apb(1'b1, `AMU_OFF_STATUS, 32'hFFFF_FFFF, q, e);
      chk_apb(q, e, 33'h0_0000_0000);
      apb(1'b0, `AMU_OFF_STATUS, 32'h0, q, e);
      chk_apb(q, e, {14'h0000, ar, 16'(48 * (b + 1))});
    end
    conclude();
  end

  // Every result against the queued expectation
  always @(posedge i_clk) begin
    if (i_rst_b && res.valid === 1'b1) begin
      chk_res(res, expq.pop_front());
    end
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
endmodule
